/* File: design/usp_pkg.sv */
// shared constants, types and register map of the serial port with baud gen
package usp_pkg;

  // register indices, byte address is four times the index
  localparam logic [7:0]  IDX_PWR    = 8'h87;
  localparam logic [7:0]  IDX_TH1    = 8'h8D;
  localparam logic [7:0]  IDX_CTRL   = 8'h98;
  localparam logic [7:0]  IDX_BUF    = 8'h99;
  localparam logic [7:0]  IDX_RELL   = 8'hAA;
  localparam logic [7:0]  IDX_RELH   = 8'hBA;
  localparam logic [7:0]  IDX_SRC    = 8'hD8;
  localparam logic [7:0]  IDX_IRQ_ST = 8'hF8;
  localparam logic [7:0]  IDX_IRQ_MK = 8'hF9;

  // reset values
  localparam logic [7:0]  RST_PWR  = 8'h00;
  localparam logic [7:0]  RST_TH1  = 8'h00;
  localparam logic [7:0]  RST_CTRL = 8'h00;
  localparam logic [7:0]  RST_RELL = 8'hD9;
  localparam logic [7:0]  RST_RELH = 8'h03;
  localparam logic [7:0]  RST_SRC  = 8'h00;
  localparam logic [7:0]  RST_MASK = 8'h00;

  // field positions
  localparam int          DOUBLER_BIT = 7;
  localparam int          SRC_BIT     = 7;
  localparam int          IRQ_RX      = 0;
  localparam int          IRQ_TX      = 1;
  localparam int          IRQ_FERR    = 2;
  localparam int          IRQ_OVR     = 3;

  // rate divisors and oversampling
  localparam int          OVS       = 16;
  localparam int          T1_DIV    = 384;
  localparam int          GEN_DIV   = 64;
  localparam int          FIX_DIV   = 64;
  localparam logic [4:0]  T1_PRE    = 5'(T1_DIV / OVS);
  localparam logic [4:0]  GEN_PRE   = 5'(GEN_DIV / OVS);
  localparam logic [4:0]  FIX_PRE   = 5'(FIX_DIV / OVS);
  localparam logic [10:0] T1_SPAN   = 11'h100;
  localparam logic [10:0] GEN_SPAN  = 11'h400;

  // receive sample points within a 16 tick bit
  localparam logic [3:0]  SMP_A     = 4'h7;
  localparam logic [3:0]  SMP_B     = 4'h8;
  localparam logic [3:0]  SMP_C     = 4'h9;
  localparam logic [3:0]  LAST_TICK = 4'hF;

  // frame lengths in bits
  localparam logic [3:0]  DATA_BITS = 4'h8;
  localparam logic [3:0]  FRAME8    = 4'hA;
  localparam logic [3:0]  FRAME9    = 4'hB;

  // frame modes
  typedef enum logic [1:0] {
    MODE_NONE = 2'h0,
    MODE_8VAR = 2'h1,
    MODE_9FIX = 2'h2,
    MODE_9VAR = 2'h3
  } usp_mode_t;

  // receiver states, gray along idle-start-data-stop
  typedef enum logic [1:0] {
    RX_IDLE  = 2'h0,
    RX_START = 2'h1,
    RX_DATA  = 2'h3,
    RX_STOP  = 2'h2
  } usp_rx_st_t;

  // serial control register layout
  typedef struct packed {
    usp_mode_t mode;
    logic      mp_en;
    logic      rx_en;
    logic      tx_ninth;
    logic      rx_ninth;
    logic      tx_done;
    logic      rx_done;
  } usp_ctrl_t;

  // baud generator settings
  typedef struct packed {
    logic       use_gen;
    logic       doubler;
    logic       fixed;
    logic [7:0] th1;
    logic [9:0] reload;
  } usp_baud_cfg_t;

endpackage

/* File: design/usp_sync.sv */
// two flip-flop synchroniser for the receive pin
`timescale 1ns/1ps
`default_nettype none
module usp_sync
  import usp_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // asynchronous in, synchronous out
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_q; // first stage, read only by the second

  // idle line is high, so reset to one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q   <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

/* File: design/usp_baud.sv */
// sixteen-times oversampling tick generator for the serial port
`timescale 1ns/1ps
`default_nettype none
module usp_baud
  import usp_pkg::*;
(
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // rate settings
  input  wire usp_baud_cfg_t cfg,
  // one pulse per sixteenth of a bit
  output logic               tick
);

  logic [4:0]  pre_q;  // prescale counter
  logic [10:0] div_q;  // period counter
  logic [4:0]  pre_lim; // prescale length
  logic [10:0] div_lim; // period length

  // fixed mode: clock/64, doubled clock/32
  always_comb begin
    if (cfg.fixed || cfg.use_gen) begin
      pre_lim = cfg.doubler ? (GEN_PRE >> 1) : GEN_PRE;
    end else begin
      pre_lim = cfg.doubler ? (T1_PRE >> 1) : T1_PRE;
    end
    if (cfg.fixed) begin
      div_lim = 11'h001;
    end else if (cfg.use_gen) begin
      div_lim = GEN_SPAN - {1'b0, cfg.reload};
    end else begin
      div_lim = T1_SPAN - {3'h0, cfg.th1};
    end
  end

  // count prescale, then period; reload 0x3FF at 1.2288 MHz gives 19200, doubled 38400
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 5'h00;
      div_q <= 11'h000;
      tick  <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (pre_q >= pre_lim - 5'h01) begin
        pre_q <= 5'h00;
        if (div_q >= div_lim - 11'h001) begin
          div_q <= 11'h000;
          tick  <= 1'b1;
        end else begin
          div_q <= div_q + 11'h001;
        end
      end else begin
        pre_q <= pre_q + 5'h01;
      end
    end
  end

endmodule
`default_nettype wire

/* File: design/usp_top.sv */
// serial port top: apb registers, transmitter, receiver, interrupt
`timescale 1ns/1ps
`default_nettype none
module usp_top
  import usp_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial pins
  input  wire logic        rx_pin,
  output logic             tx_pin,
  // interrupt
  output logic             irq
);

  // software registers
  logic [7:0]    pwr_q;     // speed control, bit 7 doubler
  logic [7:0]    th1_q;     // timer one high byte
  logic [7:0]    rell_q;    // reload low bits
  logic [7:0]    relh_q;    // reload high bits
  logic [7:0]    src_q;     // rate source select
  usp_ctrl_t     ctrl_q;    // serial control
  logic [7:0]    rxbuf_q;   // last received byte
  logic [7:0]    ist_q;     // sticky interrupt status
  logic [7:0]    imask_q;   // interrupt mask

  // bus decode
  logic          setup;     // setup phase
  logic          done;      // access completes this edge
  logic          wr;        // write completes
  logic          rd;        // read completes
  logic [7:0]    widx;      // word index of address
  logic [7:0]    rdata_c;   // read mux
  logic          hit_c;     // address is mapped

  // shared datapath
  usp_baud_cfg_t bcfg;      // rate settings
  logic          tick;      // oversample tick
  logic          rx_s;      // synchronised receive pin
  logic          nine;      // frame carries a ninth bit

  // transmitter
  logic [10:0]   tx_sh_q;   // frame shifter
  logic [3:0]    tx_left_q; // bits left including current
  logic [3:0]    tx_sub_q;  // tick within bit
  logic          tx_busy_q; // frame in flight
  logic          tx_ev;     // frame finished
  logic          tx_load;   // start a frame

  // receiver
  usp_rx_st_t    rx_st_q;   // receive state
  logic [3:0]    rx_sub_q;  // tick within bit
  logic [3:0]    rx_cnt_q;  // data bits taken
  logic [7:0]    rx_dat_q;  // assembled byte
  logic          rx_9_q;    // assembled ninth bit
  logic [1:0]    rx_smp_q;  // first two votes
  logic          rx_prev_q; // line one cycle ago
  logic          vote;      // majority decision
  logic          rx_dec;    // decision tick
  logic          rx_end;    // stop bit decided
  logic          rx_take;   // frame accepted
  logic          rx_ovr;    // frame dropped, flag still set
  logic          rx_ferr;   // stop bit found low
  logic [7:0]    ist_d;     // next status

  // bus phases: one setup, one access cycle, no waits
  assign setup = psel & ~penable;
  assign done  = psel & penable & pready;
  assign wr    = done & pwrite;
  assign rd    = done & ~pwrite;
  assign widx  = paddr[9:2];

  // read mux over the word index
  always_comb begin
    hit_c   = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    rdata_c = 8'h00;
    case (widx)
      IDX_PWR:    rdata_c = pwr_q;
      IDX_TH1:    rdata_c = th1_q;
      IDX_CTRL:   rdata_c = ctrl_q;
      IDX_BUF:    rdata_c = rxbuf_q;
      IDX_RELL:   rdata_c = rell_q;
      IDX_RELH:   rdata_c = relh_q;
      IDX_SRC:    rdata_c = src_q;
      IDX_IRQ_ST: rdata_c = ist_q;
      IDX_IRQ_MK: rdata_c = imask_q;
      default:    hit_c   = 1'b0;
    endcase
  end

  // answer latched at setup so that read data comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= {24'h00_0000, rdata_c};
      pready  <= 1'b1;
      pslverr <= ~hit_c;
    end else if (done) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // plain read/write configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_q   <= RST_PWR;
      th1_q   <= RST_TH1;
      rell_q  <= RST_RELL;
      relh_q  <= RST_RELH;
      src_q   <= RST_SRC;
      imask_q <= RST_MASK;
    end else if (wr) begin
      case (widx)
        IDX_PWR:    pwr_q   <= pwdata[7:0];
        IDX_TH1:    th1_q   <= pwdata[7:0];
        IDX_RELL:   rell_q  <= pwdata[7:0];
        IDX_RELH:   relh_q  <= pwdata[7:0];
        IDX_SRC:    src_q   <= pwdata[7:0];
        IDX_IRQ_MK: imask_q <= pwdata[7:0];
        default:    pwr_q   <= pwr_q;
      endcase
    end
  end

  // serial control: done flags take zero writes only, hardware set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= usp_ctrl_t'(RST_CTRL);
    end else begin
      if (wr && widx == IDX_CTRL) begin
        ctrl_q.mode     <= usp_mode_t'(pwdata[7:6]);
        ctrl_q.mp_en    <= pwdata[5];
        ctrl_q.rx_en    <= pwdata[4];
        ctrl_q.tx_ninth <= pwdata[3];
        ctrl_q.rx_ninth <= pwdata[2];
        ctrl_q.tx_done  <= ctrl_q.tx_done & pwdata[1];
        ctrl_q.rx_done  <= ctrl_q.rx_done & pwdata[0];
      end
      if (tx_ev) begin
        ctrl_q.tx_done <= 1'b1;
      end
      if (rx_take) begin
        ctrl_q.rx_done  <= 1'b1;
        // stop bit stands in for the ninth in mode 1, taken live
        ctrl_q.rx_ninth <= nine ? rx_9_q : vote;
      end
    end
  end

  // rate settings: reload joins high two bits over low byte
  assign bcfg.use_gen = src_q[SRC_BIT];
  assign bcfg.doubler = pwr_q[DOUBLER_BIT];
  assign bcfg.fixed   = (ctrl_q.mode == MODE_9FIX);
  assign bcfg.th1     = th1_q;
  assign bcfg.reload  = {relh_q[1:0], rell_q};
  assign nine         = ctrl_q.mode[1];

  // shared tick generator
  usp_baud u_baud (
    .pclk    (pclk),
    .presetn (presetn),
    .cfg     (bcfg),
    .tick    (tick)
  );

  // receive pin crosses into the clock domain
  usp_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (rx_pin),
    .sync_out (rx_s)
  );

  // a buffer write launches a frame; ignored while busy or in mode 0
  assign tx_load = wr && (widx == IDX_BUF) && !tx_busy_q
                   && (ctrl_q.mode != MODE_NONE);

  // transmitter shifts out start, data lsb first, ninth, stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sh_q   <= 11'h7FF;
      tx_left_q <= 4'h0;
      tx_sub_q  <= 4'h0;
      tx_busy_q <= 1'b0;
      tx_pin    <= 1'b1;
      tx_ev     <= 1'b0;
    end else begin
      tx_ev <= 1'b0;
      if (tx_load) begin
        // ninth bit from control, or the stop level in mode 1
        tx_sh_q   <= {1'b1, nine ? ctrl_q.tx_ninth : 1'b1,
                      pwdata[7:0], 1'b0};
        tx_left_q <= nine ? FRAME9 : FRAME8;
        tx_sub_q  <= 4'h0;
        tx_busy_q <= 1'b1;
        tx_pin    <= 1'b0;
      end else if (tx_busy_q && tick) begin
        tx_sub_q <= tx_sub_q + 4'h1;
        if (tx_sub_q == LAST_TICK) begin
          if (tx_left_q == 4'h1) begin
            tx_busy_q <= 1'b0;
            tx_pin    <= 1'b1;
            tx_ev     <= 1'b1;
          end else begin
            tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
            tx_pin    <= tx_sh_q[1];
            tx_left_q <= tx_left_q - 4'h1;
          end
        end
      end
    end
  end

  // three samples around mid-bit, majority wins
  assign vote   = (rx_smp_q[0] & rx_smp_q[1]) | (rx_smp_q[0] & rx_s)
                | (rx_smp_q[1] & rx_s);
  assign rx_dec = tick && (rx_sub_q == SMP_C);
  assign rx_end = rx_dec && (rx_st_q == RX_STOP);
  // accept rule: flag clear; multiprocessor needs ninth or stop high
  assign rx_ovr  = rx_end && ctrl_q.rx_done;
  assign rx_take = rx_end && !ctrl_q.rx_done
                   && (!ctrl_q.mp_en || (nine ? rx_9_q : vote));
  assign rx_ferr = rx_end && !vote;

  // received byte lands in the buffer; stop bit is ninth in mode 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxbuf_q <= 8'h00;
    end else if (rx_take) begin
      rxbuf_q <= rx_dat_q;
    end
  end

  // receiver sequence, independent of the transmitter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q   <= RX_IDLE;
      rx_sub_q  <= 4'h0;
      rx_cnt_q  <= 4'h0;
      rx_dat_q  <= 8'h00;
      rx_9_q    <= 1'b0;
      rx_smp_q  <= 2'h3;
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= rx_s;
      if (tick && rx_st_q != RX_IDLE) begin
        rx_sub_q <= rx_sub_q + 4'h1;
      end
      if (tick && (rx_sub_q == SMP_A || rx_sub_q == SMP_B)) begin
        rx_smp_q <= {rx_smp_q[0], rx_s};
      end
      case (rx_st_q)
        RX_IDLE: begin
          // falling edge of the idle-high line opens a frame
          if (ctrl_q.rx_en && ctrl_q.mode != MODE_NONE
              && rx_prev_q && !rx_s) begin
            rx_st_q  <= RX_START;
            rx_sub_q <= 4'h0;
            rx_cnt_q <= 4'h0;
          end
        end
        RX_START: begin
          // a glitch that is high at mid-bit is no start bit
          if (rx_dec) begin
            rx_st_q <= vote ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_dec) begin
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q < DATA_BITS) begin
              rx_dat_q <= {vote, rx_dat_q[7:1]};
            end else begin
              rx_9_q <= vote;
            end
            if (rx_cnt_q == (nine ? DATA_BITS : DATA_BITS - 4'h1)) begin
              rx_st_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_dec) begin
            rx_st_q <= RX_IDLE;
            if (!nine) begin
              rx_9_q <= vote;
            end
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // status: events set, a completed read clears the bits it showed
  always_comb begin
    ist_d = ist_q;
    if (rd && widx == IDX_IRQ_ST) begin
      ist_d = ist_q & ~prdata[7:0];
    end
    ist_d[IRQ_RX]   = ist_d[IRQ_RX] | rx_take;
    ist_d[IRQ_TX]   = ist_d[IRQ_TX] | tx_ev;
    ist_d[IRQ_FERR] = ist_d[IRQ_FERR] | rx_ferr;
    ist_d[IRQ_OVR]  = ist_d[IRQ_OVR] | rx_ovr;
  end

  // sticky status and the masked level interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= 8'h00;
      irq   <= 1'b0;
    end else begin
      ist_q <= ist_d;
      irq   <= |(ist_d & imask_q);
    end
  end

endmodule
`default_nettype wire

/* File: bench/usp_props.sv */
// checker on the serial port top: bus timing, pin levels, irq
`timescale 1ns/1ps
`default_nettype none
module usp_props
  import usp_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // serial out and interrupt
  input wire logic        tx_pin,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic setup;  // setup cycle of a transfer
  logic done;   // completing edge of a transfer
  logic ok;     // address bits outside the index are zero
  logic hit;    // index is in the register map
  assign setup = psel && !penable;
  assign done  = psel && penable && pready;
  assign ok    = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
  assign hit   = paddr[9:2] inside {IDX_PWR, IDX_TH1, IDX_CTRL, IDX_BUF,
                 IDX_RELL, IDX_RELH, IDX_SRC, IDX_IRQ_ST, IDX_IRQ_MK};

  a_ready_next: assert property (setup |=> pready)
    else $error("no pready after setup");
  a_ready_drop: assert property (done |=> !pready)
    else $error("pready held past completion");
  a_ready_idle: assert property (!psel |=> !pready)
    else $error("pready without request");
  a_err_unmapped: assert property (setup && ok && !hit |=> pslverr &&
    prdata == 32'h0)
    else $error("unmapped index not refused");
  a_err_mapped: assert property (setup && ok && hit |=> !pslverr)
    else $error("mapped index refused");
  a_read_upper: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  // any bit cell lasts far longer than eight clocks at the fastest rate
  a_tx_low_cell: assert property ($fell(tx_pin) |-> !tx_pin [*8])
    else $error("short low cell on tx");
  a_tx_high_cell: assert property ($rose(tx_pin) |-> tx_pin [*8])
    else $error("short high cell on tx");
  // irq drops one edge after a status read, two after a mask write
  a_irq_fall: assert property ($fell(irq) |-> $past(done) ||
    $past(done, 2))
    else $error("irq dropped with no bus cause");

  c_refused: cover property (pready && pslverr);
  c_tx_frame: cover property ($fell(tx_pin));
  c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

/* File: bench/usp_host.sv */
// far-end serial partner: decodes port frames and sends its own
`timescale 1ns/1ps
`default_nettype none
module usp_host (
  // bench clock times the bit cells
  input  wire logic        pclk,
  // serial lines seen from the far end
  input  wire logic        tx_pin,
  output logic             rx_pin,
  // cell length in clocks, eleven bit frames when nine is set, else ten
  input  wire logic [15:0] period,
  input  wire logic        nine,
  // decoded frame, bits after start, first at 0
  output logic             got,
  output logic [9:0]       frame
);
  // idle line is high between frames
  initial begin
    rx_pin = 1'b1;
    got    = 1'b0;
    frame  = 10'h000;
  end
  // decoder: centre on start, then one sample per cell
  always begin
    @(negedge tx_pin);
    repeat (period / 2) @(posedge pclk);
    frame <= 10'h000;
    for (int i = 0; i < (nine ? 10 : 9); i++) begin
      repeat (period) @(posedge pclk);
      frame[i] <= tx_pin;
    end
    got <= 1'b1;
    @(posedge pclk);
    got <= 1'b0;
  end
  // short low pulse, high again long before the start bit midpoint
  task automatic glitch(input int len);
    rx_pin <= 1'b0;
    repeat (len) @(posedge pclk);
    rx_pin <= 1'b1;
    repeat (period) @(posedge pclk);
  endtask
  // sender: start, data lsb first, ninth marks address, stop
  task automatic send(input logic [7:0] d, input logic n);
    logic [10:0] bits;
    bits = {1'b1, n, d, 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      rx_pin <= (i == (nine ? 10 : 9)) ? 1'b1 : bits[i];
      repeat (period) @(posedge pclk);
    end
  endtask
endmodule
`default_nettype wire

/* File: bench/usp_top_bench.sv */
// self-checking bench of the serial port: bus, frames, flags, irq
`timescale 1ns/1ps
`default_nettype none
module usp_top_bench
  import usp_pkg::*;
;
  // clock, reset, bus and pins
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_pin;
  logic        tx_pin;
  logic        irq;
  // partner settings and decoded frames
  logic [15:0] period;
  logic        nine;
  logic        got;
  logic [9:0]  frame;
  logic [9:0]  exp_q[$];
  int          fail_count;
  int          tests_run;
  // mode, generator on, doubler, divider byte, cell clocks
  int          tb[6][5] = '{'{1, 1, 1, 8'hFE, 64}, '{2, 1, 1, 0, 32},
                 '{2, 1, 0, 0, 64}, '{3, 1, 1, 8'hFF, 32},
                 '{3, 0, 1, 8'hFF, 192}, '{1, 0, 0, 8'hFE, 768}};

  usp_top usp_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .irq(irq));
  usp_host usp_host_i (.pclk(pclk), .tx_pin(tx_pin), .rx_pin(rx_pin),
    .period(period), .nine(nine), .got(got), .frame(frame));

  // 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [31:0] rdat,
                     output logic err);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // no limit here; if pready never comes, only the watchdog ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // idle edge, so a following call never drives psel twice in a step
    @(posedge pclk);
  endtask

  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 8'h00, r, e);
    check(r, {24'h0, exp});
  endtask

  // each decoded frame against the oldest note
  always @(posedge pclk) begin
    if (got === 1'b1) begin
      if (exp_q.size() == 0) check(32'h0, 32'h1);
      else check({22'h0, frame}, {22'h0, exp_q.pop_front()});
    end
  end

  // hang guard, well past the expected run length
  initial begin
    repeat (100000) @(posedge pclk);
    fail_count++;
    stop_test;
  end

  initial begin
    logic [31:0] r;
    logic        e;
    logic [7:0]  d;
    logic [7:0]  x;
    logic [7:0]  c;
    logic [7:0]  acc;
    logic        n;
    logic        q;
    logic [1:0]  m;
    int          k;
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h000;
    pwdata     = 32'h0;
    period     = 16'h0020;
    nine       = 1'b0;
    fail_count = 0;
    tests_run  = 0;
    void'($urandom(30));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values of the register table
    rd_chk(IDX_PWR, RST_PWR);
    rd_chk(IDX_TH1, RST_TH1);
    rd_chk(IDX_CTRL, RST_CTRL);
    rd_chk(IDX_RELL, RST_RELL);
    rd_chk(IDX_RELH, RST_RELH);
    rd_chk(IDX_SRC, RST_SRC);
    rd_chk(IDX_IRQ_MK, RST_MASK);
    // port off in mode 0: a buffer write must not start a frame
    wr_reg(IDX_BUF, 8'h00);
    check({31'h0, tx_pin}, 32'h1);
    // unmapped index is refused and reads zero in bits 31 to 1
    apb(1'b0, 8'h10, 8'h00, r, e);
    check({r[31:1], e}, 32'h1);
    wr_reg(IDX_IRQ_MK, 8'h03);
    // modes 1 to 3 and every rate source, both directions at once
    for (int t = 0; t < 6; t++) begin
      m      = 2'(tb[t][0]);
      nine   = (m != 2'h1);
      period = 16'(tb[t][4]);
      wr_reg(IDX_SRC, (tb[t][1] != 0) ? 8'h80 : 8'h00);
      wr_reg(IDX_PWR, (tb[t][2] != 0) ? 8'h80 : 8'h00);
      wr_reg(IDX_TH1, 8'(tb[t][3]));
      wr_reg(IDX_RELL, 8'(tb[t][3]));
      d = 8'($urandom);
      x = 8'($urandom);
      n = nine ? 1'($urandom) : 1'b1;
      q = 1'($urandom);
      c = {m, 1'b0, 1'b1, n, 1'b0, 2'h3};
      wr_reg(IDX_CTRL, c);
      rd_chk(IDX_CTRL, c & 8'hFC);
      exp_q.push_back(nine ? {1'b1, n, d} : {2'h1, d});
      fork
        wr_reg(IDX_BUF, d);
        usp_host_i.send(x, q);
      join
      check({31'h0, irq}, 32'h1);
      acc = 8'h00;
      k   = 0;
      while (acc != 8'h03 && k < 400) begin
        apb(1'b0, IDX_IRQ_ST, 8'h00, r, e);
        acc = acc | r[7:0];
        k++;
      end
      check({24'h0, acc}, 32'h3);
      rd_chk(IDX_BUF, x);
      rd_chk(IDX_CTRL, {c[7:3], nine ? q : 1'b1, 2'h3});
      wr_reg(IDX_CTRL, c & 8'hFC);
    end
    // multiprocessor mode with rx masked out of irq
    wr_reg(IDX_IRQ_MK, 8'h02);
    wr_reg(IDX_CTRL, 8'hF0);
    nine = 1'b1;
    // a short low pulse is no start bit and leaves no status behind
    usp_host_i.glitch(16);
    rd_chk(IDX_IRQ_ST, 8'h00);
    usp_host_i.send(8'hA5, 1'b0);
    usp_host_i.send(8'h3C, 1'b1);
    check({31'h0, irq}, 32'h0);
    rd_chk(IDX_IRQ_ST, 8'h01);
    rd_chk(IDX_BUF, 8'h3C);
    // every noted frame must have been seen on the line
    check(32'(exp_q.size()), 32'h0);
    stop_test;
  end
endmodule

bind usp_top usp_props usp_props_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tx_pin(tx_pin), .irq(irq));
`default_nettype wire
